/* File: src/svtc_core.sv */
// Serial VID target control: boot and fixed codes, serial command receiver, APB registers
//
// What this block does
// - On enable rise without power good, latch both pins as boot code.
// - Boot code clock-pin high bit: 00=1.1, 01=1.0, 10=0.9, 11=0.8 V.
// - Both targets hold boot voltage until power good rises.
// - Boot code stored; power good falling returns both targets to it.
// - Serial commands accepted only while power good is asserted.
// - Address and data are 8-bit words, most significant bit first.
// - Three addresses select output 1, output 2 or both.
// - Address byte 110xx100, 110xx010 or 110xx110; x bits ignored.
// - After start, acknowledge matching address and the one data byte after it by pulling data low.
// - Data bit 7 power-save hint ignored; no power-saving mode.
// - Seven-bit code: zero is 1.55 V, each step 12.5 mV lower.
// - New code applied right after the data acknowledge.
// - Enable rise with power good at bias rail: latch fixed-mode code.
// - Fixed code clock-pin high bit: 00=1.4, 01=1.2, 10=1.0, 11=0.8 V.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "svtc_consts.svh"

module svtc_core
  import svtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic enable_in,
  input wire logic host_power_good_in,
  input wire logic pg_at_bias_rail,
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  output svtc_target_s target_ref_out1,
  output svtc_target_s target_ref_out2,
  input wire svtc_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ==========================================
  // Helpers
  function automatic svtc_target_s svtc_level(input logic [6:0] code);
    svtc_target_s t;
    t.off = (code >= `SVTC_CODE_OFF_MIN);
    t.code = (code > `SVTC_CODE_FLOOR) ? `SVTC_CODE_FLOOR : code;
    if (t.off)
    begin
      t.code = 7'h00;
    end
    return t;
  endfunction

  function automatic svtc_target_s svtc_strap(input logic [1:0] pins, input logic fixed);
    svtc_target_s t;
    t.off = 1'b0;
    unique case (pins)
      2'b00: t.code = fixed ? `SVTC_FIX_00 : `SVTC_BOOT_00;
      2'b01: t.code = fixed ? `SVTC_FIX_01 : `SVTC_BOOT_01;
      2'b10: t.code = fixed ? `SVTC_FIX_10 : `SVTC_BOOT_10;
      2'b11: t.code = fixed ? `SVTC_FIX_11 : `SVTC_BOOT_11;
    endcase
    return t;
  endfunction

  // ==========================================
  // State
  logic [4:0] sync1_r, sync2_r, prev_r;
  logic ctrl_rx_r, ctrl_rx_nxt;
  logic fixed_r, fixed_nxt;
  logic [1:0] boot_r, boot_nxt;
  svtc_target_s t1_r, t1_nxt, t2_r, t2_nxt;
  svtc_state_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic oe_r, oe_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic err_r, err_nxt;
  logic acc_r, acc_nxt;

  // Synchronised levels: [0] scl [1] sda [2] enable [3] power good [4] bias
  logic scl_s, sda_s, en_s, pg_s, bias_s;
  logic scl_rise, scl_fall, start_det, stop_det, active;
  assign scl_s = sync2_r[0];
  assign sda_s = sync2_r[1];
  assign en_s = sync2_r[2];
  assign pg_s = sync2_r[3];
  assign bias_s = sync2_r[4];
  assign scl_rise = scl_s & ~prev_r[0];
  assign scl_fall = ~scl_s & prev_r[0];
  assign start_det = scl_s & prev_r[0] & prev_r[1] & ~sda_s;
  assign stop_det = scl_s & prev_r[0] & ~prev_r[1] & sda_s;
  // Fixed mode and missing power good both lock the receiver out
  assign active = en_s & pg_s & ~fixed_r & ctrl_rx_r;

  // ==========================================
  // Next state
  always_comb
  begin
    ctrl_rx_nxt = ctrl_rx_r;
    fixed_nxt = fixed_r;
    boot_nxt = boot_r;
    t1_nxt = t1_r;
    t2_nxt = t2_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    sel_nxt = sel_r;
    oe_nxt = oe_r;
    rd_nxt = rd_r;
    err_nxt = 1'b0;
    acc_nxt = apb_req.psel & apb_req.penable & ~acc_r;

    if (!en_s)
    begin
      t1_nxt = '{off: 1'b1, code: 7'h00};
      t2_nxt = '{off: 1'b1, code: 7'h00};
      fixed_nxt = 1'b0;
      st_nxt = SVTC_IDLE;
      oe_nxt = 1'b0;
    end
    else if (!prev_r[2])
    begin
      // Pins still carry the strap level on the enable edge
      boot_nxt = {scl_s, sda_s};
      fixed_nxt = bias_s;
      t1_nxt = svtc_strap({scl_s, sda_s}, bias_s);
      t2_nxt = svtc_strap({scl_s, sda_s}, bias_s);
      st_nxt = SVTC_IDLE;
    end
    else if (!pg_s && prev_r[3] && !fixed_r)
    begin
      t1_nxt = svtc_strap(boot_r, 1'b0);
      t2_nxt = svtc_strap(boot_r, 1'b0);
    end

    if (en_s && prev_r[2])
    begin
      if (!active)
      begin
        st_nxt = SVTC_IDLE;
        oe_nxt = 1'b0;
      end
      else if (start_det)
      begin
        st_nxt = SVTC_ADDR;
        cnt_nxt = 4'h0;
        oe_nxt = 1'b0;
      end
      else if (stop_det)
      begin
        st_nxt = SVTC_IDLE;
        oe_nxt = 1'b0;
      end
      else
      begin
        unique case (st_r)
          SVTC_IDLE:
          begin
            oe_nxt = 1'b0;
          end
          SVTC_ADDR, SVTC_DATA:
          begin
            if (scl_rise && cnt_r < `SVTC_WORD_BITS)
            begin
              sh_nxt = {sh_r[6:0], sda_s};
              cnt_nxt = cnt_r + 4'h1;
            end
            else if (scl_fall && cnt_r == `SVTC_WORD_BITS)
            begin
              cnt_nxt = 4'h0;
              if (st_r == SVTC_DATA)
              begin
                st_nxt = SVTC_ACKD;
                oe_nxt = 1'b1;
              end
              else if (sh_r[7:5] == `SVTC_ADDR_HI &&
                       (sh_r[2:0] == `SVTC_SEL_OUT1 || sh_r[2:0] == `SVTC_SEL_OUT2 ||
                        sh_r[2:0] == `SVTC_SEL_BOTH))
              begin
                st_nxt = SVTC_ACKA;
                oe_nxt = 1'b1;
                sel_nxt = sh_r[2:1];
              end
              else
              begin
                // No acknowledge; wait for the next start
                st_nxt = SVTC_IDLE;
              end
            end
          end
          SVTC_ACKA, SVTC_ACKD:
          begin
            if (scl_rise)
            begin
              cnt_nxt = 4'h1;
            end
            else if (scl_fall && cnt_r == 4'h1)
            begin
              oe_nxt = 1'b0;
              cnt_nxt = 4'h0;
              st_nxt = (st_r == SVTC_ACKA) ? SVTC_DATA : SVTC_IDLE;
              if (st_r == SVTC_ACKD)
              begin
                // Bit 7 is the power-save hint and is dropped here
                if (sel_r[1])
                begin
                  t1_nxt = svtc_level(sh_r[6:0]);
                end
                if (sel_r[0])
                begin
                  t2_nxt = svtc_level(sh_r[6:0]);
                end
              end
            end
          end
        endcase
      end
    end

    // ==========================================
    // APB: one wait state; writes land on the edge that completes the access
    if (apb_req.psel && !apb_req.penable)
    begin
      rd_nxt = 32'h0000_0000;
    end
    if (apb_req.psel && apb_req.penable)
    begin
      rd_nxt = 32'h0000_0000;
      if (apb_req.paddr == `SVTC_OFF_CTRL)
      begin
        if (apb_req.pwrite && acc_r)
        begin
          ctrl_rx_nxt = apb_req.pwdata[0];
        end
        rd_nxt = {31'h0000_0000, ctrl_rx_r};
      end
      else if (apb_req.paddr == `SVTC_OFF_STATUS)
      begin
        rd_nxt = {11'h000, en_s, pg_s, fixed_r, boot_r, t2_r, t1_r};
      end
      else
      begin
        err_nxt = 1'b1;
      end
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      prev_r <= 5'h00;
      ctrl_rx_r <= `SVTC_CTRL_RST;
      fixed_r <= 1'b0;
      boot_r <= 2'h0;
      t1_r <= '{off: 1'b1, code: 7'h00};
      t2_r <= '{off: 1'b1, code: 7'h00};
      st_r <= SVTC_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      sel_r <= 2'h0;
      oe_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      err_r <= 1'b0;
      acc_r <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_r <= {pg_at_bias_rail, host_power_good_in, enable_in, serial_data_pin_in, serial_clock_pin};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      ctrl_rx_r <= ctrl_rx_nxt;
      fixed_r <= fixed_nxt;
      boot_r <= boot_nxt;
      t1_r <= t1_nxt;
      t2_r <= t2_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      sel_r <= sel_nxt;
      oe_r <= oe_nxt;
      rd_r <= rd_nxt;
      err_r <= err_nxt;
      acc_r <= acc_nxt;
    end
  end

  // Read data is registered, so the slave answers one cycle into the access phase
  assign pready = acc_r & clk_en;
  assign prdata = acc_r ? rd_r : 32'h0000_0000;
  assign pslverr = acc_r & err_r;
  assign serial_data_pin_out = 1'b0;
  assign serial_data_pin_oe = oe_r;
  assign target_ref_out1 = t1_r;
  assign target_ref_out2 = t2_r;

endmodule
`default_nettype wire

/* File: include/svtc_consts.svh */
// Constants for the serial VID target control block
`ifndef SVTC_CONSTS_SVH
`define SVTC_CONSTS_SVH

// ==========================================
// Register map
`define SVTC_OFF_CTRL 12'h000
`define SVTC_OFF_STATUS 12'h004
`define SVTC_CTRL_RST 1'b1

// ==========================================
// Boot codes as 7-bit targets: 1.1, 1.0, 0.9, 0.8 V
`define SVTC_BOOT_00 7'h24
`define SVTC_BOOT_01 7'h2C
`define SVTC_BOOT_10 7'h34
`define SVTC_BOOT_11 7'h3C

// Fixed-mode codes as 7-bit targets: 1.4, 1.2, 1.0, 0.8 V
`define SVTC_FIX_00 7'h0C
`define SVTC_FIX_01 7'h1C
`define SVTC_FIX_10 7'h2C
`define SVTC_FIX_11 7'h3C

// ==========================================
// Code floor (0.5 V) and first off code
`define SVTC_CODE_FLOOR 7'h54
`define SVTC_CODE_OFF_MIN 7'h7C

// ==========================================
// Address byte fields: [7:5] fixed, [2:0] select plus write bit
`define SVTC_ADDR_HI 3'h6
`define SVTC_SEL_OUT1 3'h4
`define SVTC_SEL_OUT2 3'h2
`define SVTC_SEL_BOTH 3'h6

// Bits per serial word
`define SVTC_WORD_BITS 4'h8

`endif

/* File: include/svtc_pkg.sv */
// Types for the serial VID target control block
package svtc_pkg;

  typedef struct packed {
    logic off;
    logic [6:0] code;
  } svtc_target_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } svtc_apb_req_s;

  typedef enum logic [4:0] {
    SVTC_IDLE = 5'b00001,
    SVTC_ADDR = 5'b00010,
    SVTC_ACKA = 5'b00100,
    SVTC_DATA = 5'b01000,
    SVTC_ACKD = 5'b10000
  } svtc_state_e;

endpackage

/* File: sim/svtc_core_props.sv */
// Checker on the target control ports
`timescale 1ns/10ps
`default_nettype none
module svtc_core_props
  import svtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic enable_in,
  input wire logic host_power_good_in,
  input wire logic pg_at_bias_rail,
  input wire logic serial_data_pin_oe,
  input wire svtc_target_s target_ref_out1,
  input wire svtc_target_s target_ref_out2,
  input wire svtc_apb_req_s apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Off carries code zero; 0.5 V is the floor code
  function automatic logic ok_t(svtc_target_s t);
    return t.off ? t.code == 7'h00 : t.code <= 7'h54;
  endfunction
  // ==========================================
  // Targets and acknowledge
  chk_code_range: assert property (ok_t(target_ref_out1) && ok_t(target_ref_out2))
    else $error("bad target code");
  chk_ack_gate: assert property (serial_data_pin_oe |-> host_power_good_in && !pg_at_bias_rail)
    else $error("ack outside serial mode");
  chk_boot_hold: assert property ((enable_in && !host_power_good_in) [*8] |->
    $stable(target_ref_out1) && $stable(target_ref_out2)) else $error("boot target moved");
  chk_fixed_hold: assert property ((enable_in && pg_at_bias_rail) [*8] |->
    $stable(target_ref_out1) && $stable(target_ref_out2)) else $error("fixed target moved");
  chk_off_dis: assert property (!enable_in [*6] |-> target_ref_out1.off && target_ref_out2.off)
    else $error("target on while disabled");
  // ==========================================
  // Register bus
  chk_pready_two: assert property (apb_req.psel && $rose(apb_req.penable) |=> pready)
    else $error("pready late");
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside answer");
endmodule
bind svtc_core svtc_core_props i_svtc_core_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .enable_in(enable_in), .host_power_good_in(host_power_good_in), .pg_at_bias_rail(pg_at_bias_rail),
  .serial_data_pin_oe(serial_data_pin_oe), .target_ref_out1(target_ref_out1),
  .target_ref_out2(target_ref_out2), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* File: sim/svtc_host.sv */
// Host model driving the serial command link
`timescale 1ns/10ps
`default_nettype none
module svtc_host
(
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Pins double as the enable-time strap
  task automatic strap(input logic [1:0] c);
    #13 scl = c[1];
    sda_drv = c[0];
  endtask
  // Long low phase gives the device time to let go of its ack
  task automatic clk_bit(input logic b, output logic s);
    #40 sda_drv = b;
    #160 scl = 1'b1;
    #110 s = sda_wire;
    #10 scl = 1'b0;
  endtask
  task automatic send(input logic [7:0] a, input logic [7:0] d, input logic p, output logic aa, output logic ad);
    logic s;
    #13 sda_drv = 1'b1;
    #80 scl = 1'b1;
    #160 sda_drv = 1'b0;
    #160 scl = 1'b0;
    for (int i = 7; i >= 0; i--) clk_bit(a[i], s);
    clk_bit(1'b1, s);
    #160 aa = !s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    #320 ad = !s;
    if (p)
    begin
      #40 sda_drv = 1'b0;
      #160 scl = 1'b1;
      #120 sda_drv = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

/* File: sim/svtc_core_tb.sv */
// Testbench for the serial VID target control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module svtc_core_tb
  import svtc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic enable_in = 1'b0;
  logic pg = 1'b0;
  logic bias = 1'b0;
  logic clk_en = 1'b1;
  wire logic scl, sda_drv, oe, sda_out, pready, pslverr, sda_wire;
  wire logic [31:0] prdata;
  svtc_target_s t1, t2, e1, e2;
  svtc_apb_req_s apb_req = '0;
  logic [31:0] rd;
  logic er, aa, ad, x;
  int fails = 0;
  int n_checks = 0;
  logic [7:0] ca[9] = '{8'hC4, 8'hD2, 8'hCE, 8'hDC, 8'hDA, 8'hC6, 8'hC8, 8'hC5, 8'h44};
  logic [7:0] cd[9] = '{8'h80, 8'h53, 8'hFB, 8'h7C, 8'h7F, 8'h10, 8'h20, 8'h20, 8'h20};
  // Open drain with pull-up
  assign sda_wire = sda_drv & (oe ? sda_out : 1'b1);
  svtc_core i_svtc_core (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .enable_in(enable_in),
    .host_power_good_in(pg), .pg_at_bias_rail(bias), .serial_clock_pin(scl), .serial_data_pin_in(sda_wire),
    .serial_data_pin_out(sda_out), .serial_data_pin_oe(oe), .target_ref_out1(t1), .target_ref_out2(t2),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  svtc_host i_svtc_host (.sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
  initial
  begin
    forever #20 ref_clk = !ref_clk;
  end
  // ==========================================
  // Helpers
  function automatic svtc_target_s mv_t(int mv);
    return {1'b0, 7'((1550 - mv) * 2 / 25)};
  endfunction
  function automatic svtc_target_s cmd_t(logic [7:0] d);
    if (d[6:0] >= 7'h7C) return 8'h80;
    return {1'b0, d[6:0] > 7'h54 ? 7'h54 : d[6:0]};
  endfunction
  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Request held until pready is seen high at a rising edge; answer taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    apb_req <= '0;
  endtask
  task automatic boot(input int c, input int mv);
    @(posedge ref_clk);
    enable_in <= 1'b0;
    i_svtc_host.strap(c[1:0]);
    repeat (8) @(posedge ref_clk);
    `CHK({t1, t2}, 16'h8080)
    enable_in <= 1'b1;
    repeat (8) @(posedge ref_clk);
    i_svtc_host.strap(2'b11);
    i_svtc_host.send(8'hC6, 8'h10, 1'b1, aa, ad);
    `CHK({aa, t1, t2}, {1'b0, mv_t(mv), mv_t(mv)})
  endtask
  // ==========================================
  // Tests
  initial
  begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b0, 12'h008, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[15:0], 16'h8080)
    $display("test regs done");
    for (int c = 0; c < 4; c++) boot(c, 1100 - 100 * c);
    $display("test boot done");
    @(posedge ref_clk);
    pg <= 1'b1;
    e1 = mv_t(800);
    e2 = mv_t(800);
    foreach (ca[k])
    begin
      i_svtc_host.send(ca[k], cd[k], k == 8, aa, ad);
      x = ca[k][7:5] == 3'b110 && !ca[k][0] && ca[k][2:1] != 2'b00;
      if (x && ca[k][2]) e1 = cmd_t(cd[k]);
      if (x && ca[k][1]) e2 = cmd_t(cd[k]);
      `CHK({aa, ad, t1, t2}, {x, x, e1, e2})
    end
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[15:0], {e2, e1})
    apb(1'b1, 12'h000, 32'h0);
    i_svtc_host.send(8'hC6, 8'h00, 1'b1, aa, ad);
    `CHK({aa, t1, t2}, {1'b0, e1, e2})
    apb(1'b1, 12'h000, 32'h1);
    // Three frozen edges: the power-good fall must not reach the targets yet
    clk_en <= 1'b0;
    pg <= 1'b0;
    repeat (3) @(posedge ref_clk);
    clk_en <= 1'b1;
    @(negedge ref_clk);
    `CHK({t1, t2}, {e1, e2})
    repeat (8) @(posedge ref_clk);
    `CHK({t1, t2}, {mv_t(800), mv_t(800)})
    $display("test serial done");
    enable_in <= 1'b0;
    bias <= 1'b1;
    pg <= 1'b1;
    for (int c = 0; c < 4; c++) boot(c, 1400 - 200 * c);
    $display("test fixed done");
    end_sim();
  end
endmodule
`default_nettype wire
